// file: rfoc_rail_fault.sv
// Purpose: supervisory logic of a multiphase core rail controller
// Assumes: pin levels and converter codes are asynchronous and are synchronised here
// Notes: registers over AHB-Lite, zero wait states, always OKAY
// Summary of operation
// - select bits low: sampled initial offset only
// - select bits high: continuous offset, input minus 1.2V
// - sample offset at enable rise; below 0.3V zero
// - sample above 0.3V gives input minus 1.2V
// - core and north-bridge offsets from separate inputs
// - step up forces three phases; down holds
// - step compensation decoded from both straps
// - light-load step down blocks low side, 4 pulses
// - ramp from strap A, changes in diode emulation
// - monitor voltage to 511 levels of 6.25 mV
// - fast transient gives one on-time boost pulse
// - sustained overcurrent needs continuous trigger delay
// - peak overcurrent trips with no delay
// - any trip asserts alert, then action delay
// - still above after delay: all switches off
// - overvoltage above floor or reference plus 325mV
// - overvoltage latched: low side on, high off
// - overvoltage persists 1us; shuts other rail down
// - negative sense under overvoltage turns low side off
// - 500mV under reference for 3us: all off
// - supply low 3us: all switches forced off
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module rfoc_rail_fault
  import rfoc_pkg::*;
#(
  parameter int PHASES = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire rfoc_pins_t pins,
  output logic [PHASES-1:0] highSideEnable,
  output logic [PHASES-1:0] lowSideEnable,
  output logic [1:0] phaseCount,
  output logic signed [12:0] coreOffset,
  output logic signed [12:0] nbOffset,
  output logic [1:0] dvidComp,
  output logic [1:0] rampSelect,
  output logic boostPulse,
  output logic overcurrentAlert_n,
  output logic otherRailShutdown
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  rfoc_state_t st;
  rfoc_state_t next_st;
  logic enRise;
  logic enOn;
  logic ovCond;
  logic uvCond;
  logic sustTrip;
  logic peakTrip;
  logic above;
  logic [13:0] level;
  logic [31:0] rmux;

  assign enOn = st.s2.enable;
  assign enRise = st.s2.enable & ~st.prev.enable;

  always_comb begin
    next_st = st;
    // two-stage synchroniser and edge history
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;

    // offsets
    if (st.s2.coreSel) begin
      next_st.coreOfs = $signed({1'b0, st.s2.coreOfsMv}) - OFS_BIAS_MV;
    end else if (enRise) begin
      if (st.s2.coreOfsMv < OFS_MIN_MV) begin
        next_st.coreOfs = '0;
      end else begin
        next_st.coreOfs = $signed({1'b0, st.s2.coreOfsMv}) - OFS_BIAS_MV;
      end
    end else if (!enOn) begin
      next_st.coreOfs = '0;
    end
    if (st.s2.nbSel) begin
      next_st.nbOfs = $signed({1'b0, st.s2.nbOfsMv}) - OFS_BIAS_MV;
    end else if (enRise) begin
      if (st.s2.nbOfsMv < OFS_MIN_MV) begin
        next_st.nbOfs = '0;
      end else begin
        next_st.nbOfs = $signed({1'b0, st.s2.nbOfsMv}) - OFS_BIAS_MV;
      end
    end else if (!enOn) begin
      next_st.nbOfs = '0;
    end

    // phase configuration and light-load step down
    if (st.s2.dvidUp && !st.prev.dvidUp) begin
      next_st.phases = 2'h3;
    end else if (st.s2.dvidDown && !st.prev.dvidDown) begin
      next_st.phases = st.phases;
    end else if (st.phasesReq != st.phases && !st.s2.dvidUp) begin
      next_st.phases = st.phasesReq;
    end
    if (st.lsBlock && st.s2.pwmPulse && !st.prev.pwmPulse) begin
      next_st.pulseCnt = st.pulseCnt + 3'h1;
      if (st.pulseCnt == DYNAMIC_VOLTAGE_STEP_PULSES - 3'h1) begin
        next_st.lsBlock = 1'b0;
      end
    end
    if (st.s2.dvidDown && !st.prev.dvidDown && st.s2.lightLoad) begin
      next_st.lsBlock = 1'b1;
      next_st.pulseCnt = '0;
    end

    // current monitor conversion
    level = st.s2.imonQ / CURRENT_MONITOR_NODE_LSB_Q;
    next_st.iout = (level > 14'(CURRENT_MONITOR_NODE_LEVELS)) ? CURRENT_MONITOR_NODE_LEVELS : level[8:0];

    // fast transient boost pulse
    if (st.boost) begin
      if (st.onCnt == 8'h00) begin
        next_st.boost = 1'b0;
      end else begin
        next_st.onCnt = st.onCnt - 8'h01;
      end
    end else if (st.s2.fastDet && !st.prev.fastDet) begin
      next_st.boost = 1'b1;
      next_st.onCnt = (st.onTime == 8'h00) ? 8'h00 : st.onTime - 8'h01;
    end

    // dual overcurrent
    if (st.iout > st.tdcThr) begin
      if (st.tdcCnt != 16'hFFFF) begin
        next_st.tdcCnt = st.tdcCnt + 16'h0001;
      end
    end else begin
      next_st.tdcCnt = '0;
    end
    sustTrip = (st.iout > st.tdcThr) && (st.tdcCnt >= st.trigDelay);
    peakTrip = st.s2.peakLevel > st.spikeThr;
    above = (st.iout > st.tdcThr) || peakTrip;
    if (st.ocAlert) begin
      if (st.actCnt >= st.actDelay) begin
        if (above) begin
          next_st.ocShut = 1'b1;
        end else if (!st.ocShut) begin
          next_st.ocAlert = 1'b0;
        end
      end else begin
        next_st.actCnt = st.actCnt + 16'h0001;
      end
    end else if (sustTrip || peakTrip) begin
      next_st.ocAlert = 1'b1;
      next_st.actCnt = '0;
    end

    // overvoltage, undervoltage, negative voltage
    if (st.s2.refMv < OV_FLOOR_MV[11:0]) begin
      ovCond = {1'b0, st.s2.senseMv} > OV_FLOOR_MV + OV_MARGIN_MV;
    end else begin
      ovCond = {1'b0, st.s2.senseMv} > {1'b0, st.s2.refMv} + OV_MARGIN_MV;
    end
    uvCond = {1'b0, st.s2.senseMv} + UV_MARGIN_MV < {1'b0, st.s2.refMv};
    next_st.ovCnt = (ovCond && st.ovCnt != OV_CYCLES) ? st.ovCnt + 10'h001 : '0;
    if (ovCond && st.ovCnt == OV_CYCLES - 10'h001) begin
      next_st.ovLatch = 1'b1;
    end
    next_st.uvCnt = (uvCond && st.uvCnt != UV_CYCLES) ? st.uvCnt + 10'h001 : '0;
    if (uvCond && st.uvCnt == UV_CYCLES - 10'h001) begin
      next_st.uvLatch = 1'b1;
    end
    next_st.nvGuard = st.ovLatch && st.s2.senseNeg;
    if (!st.s2.supplyOk) begin
      if (st.uvloCnt != SUPPLY_LOCKOUT_CYCLES) begin
        next_st.uvloCnt = st.uvloCnt + 10'h001;
      end
      if (st.uvloCnt == SUPPLY_LOCKOUT_CYCLES - 10'h001) begin
        next_st.supply_lockout = 1'b1;
      end
    end else begin
      next_st.uvloCnt = '0;
      next_st.supply_lockout = 1'b0;
    end

    // enable low clears the fault latches
    if (!enOn) begin
      next_st.ovLatch = 1'b0;
      next_st.uvLatch = 1'b0;
      next_st.nvGuard = 1'b0;
      next_st.ocAlert = 1'b0;
      next_st.ocShut = 1'b0;
      next_st.ovCnt = '0;
      next_st.uvCnt = '0;
      next_st.tdcCnt = '0;
      next_st.lsBlock = 1'b0;
    end

    if (st.supply_lockout || st.uvLatch || st.ocShut) begin
      next_st.fault = RFOC_OFF;
    end else if (st.ovLatch) begin
      next_st.fault = RFOC_CLAMP;
    end else begin
      next_st.fault = RFOC_RUN;
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    if (st.wrPend) begin
      unique case (st.wrAddr)
        REG_CTRL: begin
          next_st.onTime = hwdata[7:0];
          next_st.phasesReq = hwdata[9:8];
        end
        REG_TDC: next_st.tdcThr = hwdata[8:0];
        REG_SPIKE: next_st.spikeThr = hwdata[8:0];
        REG_TRIG: next_st.trigDelay = hwdata[15:0];
        REG_ACT: next_st.actDelay = hwdata[15:0];
        default: next_st.wrPend = 1'b0;
      endcase
    end
    next_st.wrPend = hsel && htrans[1] && hready && hwrite;
    next_st.wrAddr = haddr[7:0];
    rmux = '0;
    unique case (haddr[7:0])
      REG_CTRL: rmux = {22'h0, next_st.phasesReq, next_st.onTime};
      REG_TDC: rmux = {23'h0, next_st.tdcThr};
      REG_SPIKE: rmux = {23'h0, next_st.spikeThr};
      REG_TRIG: rmux = {16'h0, next_st.trigDelay};
      REG_ACT: rmux = {16'h0, next_st.actDelay};
      REG_STAT: rmux = {21'h0, st.phases, st.fault, st.supply_lockout, st.nvGuard,
                        st.uvLatch, st.ovLatch, st.ocShut, st.ocAlert};
      REG_IOUT: rmux = {23'h0, st.iout};
      REG_OFS: rmux = {3'h0, st.nbOfs, 3'h0, st.coreOfs};
      default: rmux = '0;
    endcase
    if (hsel && htrans[1] && hready && !hwrite) begin
      next_st.rdata = rmux;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.fault <= RFOC_RUN;
      st.onTime <= ONTIME_RST;
      st.phasesReq <= PHASES_RST;
      st.phases <= PHASES_RST;
      st.tdcThr <= TDC_RST;
      st.spikeThr <= SPIKE_RST;
      st.trigDelay <= TRIG_RST;
      st.actDelay <= ACT_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign phaseCount = st.phases;
  assign coreOffset = st.coreOfs;
  assign nbOffset = st.nbOfs;
  assign dvidComp = {st.s2.strapB, st.s2.strapA};
  assign rampSelect = {st.s2.diodeEm, st.s2.strapA};
  assign boostPulse = st.boost;
  assign overcurrentAlert_n = ~st.ocAlert;
  assign otherRailShutdown = st.ovLatch | st.uvLatch;

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : gPhase
      logic act;
      assign act = enOn && (g < int'(st.phases));
      assign highSideEnable[g] = act && st.fault == RFOC_RUN;
      assign lowSideEnable[g] = act && ((st.fault == RFOC_RUN && !st.lsBlock) ||
                                 (st.fault == RFOC_CLAMP && !st.nvGuard));
    end
  endgenerate

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // offsets: sampled at the enable edge, or followed while external
  init_offset_a: assert property (
    enRise && !st.s2.coreSel && st.s2.coreOfsMv < OFS_MIN_MV |=> coreOffset == 13'sh0000)
    else $error("initial offset not zero");
  init_nb_a: assert property (
    enRise && !st.s2.nbSel && st.s2.nbOfsMv < OFS_MIN_MV |=> nbOffset == 13'sh0000)
    else $error("north-bridge initial offset not zero");
  init_pos_a: assert property (
    enRise && !st.s2.coreSel && st.s2.coreOfsMv >= OFS_MIN_MV
    |=> coreOffset == $signed({1'b0, $past(st.s2.coreOfsMv)}) - OFS_BIAS_MV)
    else $error("initial offset wrong");
  ext_offset_a: assert property (
    st.s2.coreSel |=> coreOffset == $signed({1'b0, $past(st.s2.coreOfsMv)}) - OFS_BIAS_MV)
    else $error("bad external offset");
  ext_nb_a: assert property (
    st.s2.nbSel |=> nbOffset == $signed({1'b0, $past(st.s2.nbOfsMv)}) - OFS_BIAS_MV)
    else $error("bad north-bridge offset");

  // phase count and light-load step down
  dynamic_voltage_step_up_a: assert property (
    st.s2.dvidUp && !st.prev.dvidUp |=> phaseCount == 2'h3)
    else $error("step up not three phases");
  dynamic_voltage_step_hold_a: assert property (
    st.s2.dvidDown && !st.prev.dvidDown && !(st.s2.dvidUp && !st.prev.dvidUp)
    |=> $stable(phaseCount)) else $error("step down changed phases");
  ls_block_a: assert property (
    st.lsBlock && st.fault != RFOC_CLAMP |-> lowSideEnable == '0)
    else $error("low side on during step-down block");

  // overvoltage, undervoltage, negative voltage, lockout
  ov_clamp_a: assert property (
    st.fault == RFOC_CLAMP && !st.nvGuard && enOn && st.phases != 0
    |-> lowSideEnable[0] && highSideEnable == '0) else $error("clamp gates wrong");
  uv_off_a: assert property (
    st.fault == RFOC_OFF |-> highSideEnable == '0 && lowSideEnable == '0)
    else $error("switch on in off state");
  ov_hold_a: assert property (
    $rose(st.ovLatch) |-> $past(st.ovCnt) == OV_CYCLES - 10'h001)
    else $error("overvoltage latched early");
  uv_hold_a: assert property (
    $rose(st.uvLatch) |-> $past(st.uvCnt) == UV_CYCLES - 10'h001)
    else $error("undervoltage latched early");
  nv_guard_a: assert property (
    st.nvGuard |-> ##1 (lowSideEnable == '0) or ##1 !st.nvGuard)
    else $error("low side on under negative guard");
  supply_lockout_off_a: assert property (
    $rose(st.supply_lockout) |=> st.fault == RFOC_OFF ##1 highSideEnable == '0)
    else $error("lockout left switches on");
  latch_clear_a: assert property (
    !enOn |=> !st.ovLatch && !st.uvLatch && overcurrentAlert_n)
    else $error("fault latch survived enable low");

  // overcurrent and boost pulse
  peak_alert_a: assert property (
    !st.ocAlert && peakTrip && enOn |=> !overcurrentAlert_n)
    else $error("alert not raised");
  alert_wait_a: assert property (
    st.ocAlert && enOn && st.actCnt < st.actDelay |=> !overcurrentAlert_n)
    else $error("alert dropped inside action delay");
  oc_shut_a: assert property (
    st.ocShut |=> highSideEnable == '0 && lowSideEnable == '0)
    else $error("switch on after overcurrent shutdown");
  boost_start_a: assert property (
    !st.boost && st.s2.fastDet && !st.prev.fastDet |=> boostPulse)
    else $error("boost pulse missing");
  boost_end_a: assert property (
    st.boost && st.onCnt == 8'h00 |=> !boostPulse)
    else $error("boost pulse too long");

  ov_seen_c: cover property ($rose(st.ovLatch));
  oc_shut_c: cover property ($rose(st.ocShut));
  boost_c: cover property ($rose(boostPulse) ##[1:8] $fell(boostPulse));
  ls_block_c: cover property ($fell(st.lsBlock));
  nv_guard_c: cover property ($rose(st.nvGuard));
endmodule

// file: rfoc_pkg.sv
// Purpose: shared constants and types of the rail fault and offset control block
// Assumes: 250 MHz clock; analog levels arrive as digital codes from pin converters
// Notes: voltages in mV, current monitor in quarter-mV units
package rfoc_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int OV_DELAY_NS = 1000;
  localparam int UV_DELAY_NS = 3000;
  localparam int SUPPLY_LOCKOUT_DELAY_NS = 3000;
  localparam logic [9:0] OV_CYCLES = 10'(OV_DELAY_NS * CLK_MHZ / 1000);
  localparam logic [9:0] UV_CYCLES = 10'(UV_DELAY_NS * CLK_MHZ / 1000);
  localparam logic [9:0] SUPPLY_LOCKOUT_CYCLES = 10'(SUPPLY_LOCKOUT_DELAY_NS * CLK_MHZ / 1000);
  localparam logic [2:0] DYNAMIC_VOLTAGE_STEP_PULSES = 3'h4;
  // ----------------------------------------
  // analog thresholds
  // ----------------------------------------
  localparam logic [12:0] OV_FLOOR_MV = 13'h0384;
  localparam logic [12:0] OV_MARGIN_MV = 13'h0145;
  localparam logic [12:0] UV_MARGIN_MV = 13'h01F4;
  localparam logic [11:0] OFS_MIN_MV = 12'h12C;
  localparam logic signed [12:0] OFS_BIAS_MV = 13'sh04B0;
  localparam logic [13:0] CURRENT_MONITOR_NODE_LSB_Q = 14'h0019;
  localparam logic [8:0] CURRENT_MONITOR_NODE_LEVELS = 9'h1FF;
  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TDC = 8'h04;
  localparam logic [7:0] REG_SPIKE = 8'h08;
  localparam logic [7:0] REG_TRIG = 8'h0C;
  localparam logic [7:0] REG_ACT = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_IOUT = 8'h18;
  localparam logic [7:0] REG_OFS = 8'h1C;
  localparam logic [7:0] ONTIME_RST = 8'h40;
  localparam logic [1:0] PHASES_RST = 2'h3;
  localparam logic [8:0] TDC_RST = 9'h1C0;
  localparam logic [8:0] SPIKE_RST = 9'h1F0;
  localparam logic [15:0] TRIG_RST = 16'h0100;
  localparam logic [15:0] ACT_RST = 16'h0100;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RFOC_RUN = 3'b001,
    RFOC_CLAMP = 3'b010,
    RFOC_OFF = 3'b100
  } rfoc_fault_t;
  typedef struct packed {
    logic enable;
    logic supplyOk;
    logic coreSel;
    logic nbSel;
    logic strapA;
    logic strapB;
    logic dvidUp;
    logic dvidDown;
    logic lightLoad;
    logic pwmPulse;
    logic fastDet;
    logic diodeEm;
    logic senseNeg;
    logic [11:0] senseMv;
    logic [11:0] refMv;
    logic [11:0] coreOfsMv;
    logic [11:0] nbOfsMv;
    logic [13:0] imonQ;
    logic [8:0] peakLevel;
  } rfoc_pins_t;
  typedef struct packed {
    rfoc_pins_t s1;
    rfoc_pins_t s2;
    rfoc_pins_t prev;
    rfoc_fault_t fault;
    logic signed [12:0] coreOfs;
    logic signed [12:0] nbOfs;
    logic [1:0] phases;
    logic lsBlock;
    logic [2:0] pulseCnt;
    logic [8:0] iout;
    logic [15:0] tdcCnt;
    logic [15:0] actCnt;
    logic ocAlert;
    logic ocShut;
    logic [9:0] ovCnt;
    logic [9:0] uvCnt;
    logic [9:0] uvloCnt;
    logic ovLatch;
    logic uvLatch;
    logic supply_lockout;
    logic nvGuard;
    logic boost;
    logic [7:0] onCnt;
    logic [7:0] onTime;
    logic [1:0] phasesReq;
    logic [8:0] tdcThr;
    logic [8:0] spikeThr;
    logic [15:0] trigDelay;
    logic [15:0] actDelay;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
  } rfoc_state_t;
endpackage

// file: rfoc_stage_model.sv
// Purpose: switching pulse source of the power stage, driven by the high-side gate outputs
// Assumes: pin levels are set by the bench and passed through
// Notes: switching pulses only while some high side is permitted
`timescale 1ns/1ps
module rfoc_stage_model
  import rfoc_pkg::*;
#(
  parameter int PHASES = 3
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [PHASES-1:0] highSide,
  input wire logic [PHASES-1:0] lowSide,
  input wire rfoc_pins_t pinsIn,
  output rfoc_pins_t pinsOut
);
  logic [3:0] swCnt;
  // ----------------------------------------
  // switching pulse source
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      swCnt <= 4'h0;
    end else if (|highSide) begin
      swCnt <= swCnt + 4'h1;
    end else begin
      swCnt <= 4'h0;
    end
  end
  always_comb begin
    pinsOut = pinsIn;
    pinsOut.pwmPulse = swCnt[3];
  end
endmodule

// file: rfoc_rail_fault_bench.sv
// Purpose: self-checking bench of the rail fault and offset control block
// Assumes: zero-wait AHB-Lite slave; pin levels given as digital codes
// Notes: prints only mismatches and the verdict
`timescale 1ns/1ps
module rfoc_rail_fault_bench
  import rfoc_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rv;
  rfoc_pins_t pb;
  rfoc_pins_t pm;
  logic [2:0] hs;
  logic [2:0] ls;
  logic [1:0] phaseCount;
  logic [1:0] dvidComp;
  logic [1:0] rampSelect;
  logic signed [12:0] coreOffset;
  logic signed [12:0] nbOffset;
  logic boostPulse;
  logic alertN;
  logic other;
  int badCount = 0;
  int totalChecks = 0;
  int n;
  always #2 clock = ~clock;
  rfoc_stage_model stage_u (.clock(clock), .rst_n(rst_n), .highSide(hs),
    .lowSide(ls), .pinsIn(pb), .pinsOut(pm));
  rfoc_rail_fault dut_u (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pins(pm), .highSideEnable(hs), .lowSideEnable(ls), .phaseCount(phaseCount),
    .coreOffset(coreOffset), .nbOffset(nbOffset), .dvidComp(dvidComp),
    .rampSelect(rampSelect), .boostPulse(boostPulse),
    .overcurrentAlert_n(alertN), .otherRailShutdown(other));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rv, exp);
  endtask
  task automatic rearm;
    pb.enable <= 1'b0;
    cyc(6);
    pb.enable <= 1'b1;
    cyc(6);
  endtask
  task automatic tallyAndFinish;
    if (badCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(30000);
    badCount++;
    tallyAndFinish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    pb = '0;
    pb.supplyOk = 1'b1;
    pb.senseMv = 12'd1000;
    pb.refMv = 12'd1000;
    pb.coreOfsMv = 12'd1500;
    pb.nbOfsMv = 12'd200;
    cyc(12);
    rst_n <= 1'b1;
    pb.enable <= 1'b1;
    rdChk(REG_CTRL, {22'h0, PHASES_RST, ONTIME_RST});
    rdChk(REG_TDC, {23'h0, TDC_RST});
    rdChk(REG_SPIKE, {23'h0, SPIKE_RST});
    rdChk(REG_TRIG, {16'h0, TRIG_RST});
    rdChk(REG_ACT, {16'h0, ACT_RST});
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    rdChk(8'h20, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({19'h0, coreOffset}, 32'h012C);
    chk({19'h0, nbOffset}, 32'h0);
    pb.coreOfsMv <= 12'd800;
    cyc(8);
    chk({19'h0, coreOffset}, 32'h012C);
    pb.coreSel <= 1'b1;
    pb.nbSel <= 1'b1;
    pb.coreOfsMv <= 12'd1000;
    pb.nbOfsMv <= 12'd1500;
    cyc(8);
    chk({19'h0, coreOffset}, 32'h1F38);
    rdChk(REG_OFS, 32'h012C_1F38);
    for (int i = 0; i < 8; i++) begin
      {pb.diodeEm, pb.strapB, pb.strapA} <= 3'(i);
      cyc(5);
      chk({30'h0, dvidComp}, {30'h0, i[1:0]});
      chk({30'h0, rampSelect}, {30'h0, i[2], i[0]});
    end
    pb.imonQ <= 14'd2499;
    cyc(6);
    rdChk(REG_IOUT, 32'd99);
    pb.imonQ <= 14'd12775;
    cyc(6);
    rdChk(REG_IOUT, 32'd511);
    pb.imonQ <= 14'h3FFF;
    cyc(6);
    rdChk(REG_IOUT, 32'd511);
    pb.imonQ <= 14'd2500;
    bus(REG_CTRL, 1'b1, 32'h0000_0108);
    cyc(6);
    pb.dvidDown <= 1'b1;
    cyc(6);
    chk({30'h0, phaseCount}, 32'h1);
    pb.dvidUp <= 1'b1;
    cyc(6);
    chk({30'h0, phaseCount}, 32'h3);
    pb.fastDet <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clock);
      if (boostPulse === 1'b1) n++;
    end
    chk(32'(n), 32'd8);
    pb.fastDet <= 1'b0;
    pb.dvidUp <= 1'b0;
    pb.dvidDown <= 1'b0;
    bus(REG_CTRL, 1'b1, 32'h0000_0308);
    bus(REG_TRIG, 1'b1, 32'd40);
    bus(REG_ACT, 1'b1, 32'd60);
    pb.imonQ <= 14'd11500;
    cyc(20);
    chk({31'h0, alertN}, 32'h1);
    cyc(40);
    chk({31'h0, alertN}, 32'h0);
    pb.imonQ <= 14'd2500;
    cyc(80);
    chk({31'h0, alertN}, 32'h1);
    bus(REG_STAT, 1'b0, 32'h0);
    chk({31'h0, rv[1]}, 32'h0);
    pb.peakLevel <= SPIKE_RST;
    cyc(20);
    chk({31'h0, alertN}, 32'h1);
    pb.peakLevel <= SPIKE_RST + 9'h1;
    cyc(6);
    chk({31'h0, alertN}, 32'h0);
    cyc(80);
    chk({26'h0, hs, ls}, 32'h0);
    pb.peakLevel <= 9'h0;
    rearm();
    bus(REG_STAT, 1'b0, 32'h0);
    chk({30'h0, rv[1:0]}, 32'h0);
    pb.senseMv <= 12'd1325;
    cyc(300);
    chk({31'h0, other}, 32'h0);
    pb.senseMv <= 12'd1326;
    cyc(200);
    chk({31'h0, other}, 32'h0);
    cyc(60);
    chk({26'h0, hs, ls}, 32'h07);
    chk({31'h0, other}, 32'h1);
    pb.senseNeg <= 1'b1;
    cyc(6);
    chk({26'h0, hs, ls}, 32'h0);
    pb.senseNeg <= 1'b0;
    cyc(6);
    chk({26'h0, hs, ls}, 32'h07);
    pb.senseMv <= 12'd1000;
    pb.refMv <= 12'd800;
    rearm();
    chk({31'h0, other}, 32'h0);
    pb.senseMv <= 12'd1225;
    cyc(300);
    chk({31'h0, other}, 32'h0);
    pb.senseMv <= 12'd1226;
    cyc(260);
    chk({31'h0, other}, 32'h1);
    pb.senseMv <= 12'd1000;
    pb.refMv <= 12'd1000;
    rearm();
    pb.senseMv <= 12'd501;
    cyc(800);
    chk({31'h0, other}, 32'h0);
    pb.senseMv <= 12'd499;
    cyc(700);
    chk({31'h0, other}, 32'h0);
    cyc(70);
    chk({25'h0, hs, ls, other}, 32'h1);
    pb.senseMv <= 12'd1000;
    rearm();
    pb.supplyOk <= 1'b0;
    cyc(700);
    bus(REG_STAT, 1'b0, 32'h0);
    chk({31'h0, rv[5]}, 32'h0);
    cyc(70);
    chk({26'h0, hs, ls}, 32'h0);
    bus(REG_STAT, 1'b0, 32'h0);
    chk({31'h0, rv[5]}, 32'h1);
    pb.supplyOk <= 1'b1;
    cyc(6);
    bus(REG_STAT, 1'b0, 32'h0);
    chk({31'h0, rv[5]}, 32'h0);
    pb.lightLoad <= 1'b1;
    pb.dvidDown <= 1'b1;
    cyc(6);
    chk({26'h0, hs, ls}, 32'h38);
    cyc(100);
    chk({26'h0, hs, ls}, 32'h3F);
    pb.dvidDown <= 1'b0;
    pb.coreSel <= 1'b0;
    pb.nbSel <= 1'b0;
    pb.coreOfsMv <= 12'd200;
    pb.nbOfsMv <= 12'd1500;
    rearm();
    chk({19'h0, coreOffset}, 32'h0);
    chk({19'h0, nbOffset}, 32'h012C);
    tallyAndFinish();
  end
endmodule
